// >>> logic/isl_pkg.sv
// Shared constants of the interrupt status latch bank
package isl_pkg;

    // ==========================================================
    // Sizes
    // ==========================================================
    localparam int unsigned NUM_SRC    = 8;
    localparam int unsigned DATA_W     = 32;
    localparam int unsigned REG_W      = 8;

    // ==========================================================
    // Register indices, byte address is four times the index
    // ==========================================================
    localparam logic [7:0]  IDX_LATCH_EN   = 8'h20;
    localparam logic [7:0]  IDX_LINK_EVENT = 8'h26;
    localparam logic [7:0]  IDX_AMP_A      = 8'h27;
    localparam logic [7:0]  IDX_AMP_B      = 8'h28;
    localparam logic [7:0]  IDX_DLL_LOCK   = 8'h29;
    localparam logic [7:0]  IDX_PIN_SEL    = 8'h2C;
    localparam logic [7:0]  IDX_EVT_STATUS = 8'h30;
    localparam logic [7:0]  IDX_EVT_MASK   = 8'h31;

    // ==========================================================
    // Source slots in enable, pin-select, event and mask words
    // ==========================================================
    localparam int unsigned SRC_LANE   = 0;
    localparam int unsigned SRC_JITTER = 1;
    localparam int unsigned SRC_AMP0   = 2;
    localparam int unsigned SRC_AMP1   = 3;
    localparam int unsigned SRC_AMP2   = 4;
    localparam int unsigned SRC_AMP3   = 5;
    localparam int unsigned SRC_DLL_LO = 6;
    localparam int unsigned SRC_DLL_HI = 7;

    // ==========================================================
    // Bit positions inside the status registers
    // ==========================================================
    localparam int unsigned BIT_LANE   = 5;
    localparam int unsigned BIT_JITTER = 2;
    localparam int unsigned BIT_AMP_HI = 7;
    localparam int unsigned BIT_AMP_LO = 3;
    localparam int unsigned BIT_DLL_HI = 6;
    localparam int unsigned BIT_DLL_LO = 4;

    // ==========================================================
    // Values after reset and bus answers
    // ==========================================================
    localparam logic [7:0]  RST_REG      = 8'h00;
    localparam logic [31:0] RST_WORD     = 32'h0000_0000;
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_DECERR  = 2'h3;

endpackage

// >>> logic/isl_flag_cell.sv
// One status flag: live or sticky, with clear and event pulse
`timescale 1ns/100ps
module isl_flag_cell (
    input  wire logic clk_in,
    input  wire logic rst_in,
    input  wire logic latch_en_in,
    input  wire logic live_in,
    input  wire logic clear_in,
    output logic      flag_out,
    output logic      request_out,
    output logic      event_out
);

    logic latch_ff;
    logic live_d_ff;
    logic nxt_latch;

    // ==========================================================
    // Sticky latch, set beats a clear in the same cycle
    // ==========================================================
    assign nxt_latch = !latch_en_in ? 1'h0 :
                       live_in      ? 1'h1 :
                       clear_in     ? 1'h0 : latch_ff;

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            latch_ff  <= 1'h0;
            live_d_ff <= 1'h0;
        end else begin
            latch_ff  <= nxt_latch;
            live_d_ff <= live_in;
        end
    end

    // ==========================================================
    // Read view and pin request
    // ==========================================================
    assign flag_out    = latch_en_in ? latch_ff : live_in;
    assign request_out = latch_en_in & latch_ff;
    assign event_out   = live_in & ~live_d_ff;

endmodule

// >>> logic/isl_irq_pin.sv
// One active-low interrupt pin fed by the sources routed to it
`timescale 1ns/100ps
module isl_irq_pin #(
    parameter int unsigned NUM_SRC  = 8,
    parameter logic        PIN_CODE = 1'h0
) (
    input  wire logic               clk_in,
    input  wire logic               rst_in,
    input  wire logic [NUM_SRC-1:0] request_in,
    input  wire logic [NUM_SRC-1:0] pin_sel_in,
    output logic                    pin_n_out
);

    logic               pin_n_ff;
    logic [NUM_SRC-1:0] routed;

    // ==========================================================
    // Route and combine
    // ==========================================================
    assign routed = request_in & (PIN_CODE ? pin_sel_in : ~pin_sel_in);

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            pin_n_ff <= 1'h1;
        end else begin
            pin_n_ff <= ~(|routed);
        end
    end

    assign pin_n_out = pin_n_ff;

endmodule

// >>> logic/isl_status_bank.sv
// Interrupt status latch bank with AXI4-Lite register access
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/100ps

module isl_status_bank #(
    parameter int unsigned ADDR_W = 12
) (
    input  wire logic              REF_CLK_IN,
    input  wire logic              SYS_RST_IN,
    input  wire logic              LANE_BUFFER_ERROR_IN,
    input  wire logic              STROBE_OUTSIDE_WINDOW_IN,
    input  wire logic [3:0]        AMP_ERROR_IN,
    input  wire logic [1:0]        DELAY_LOOP_LOCKED_IN,
    input  wire logic [ADDR_W-1:0] S_AXI_AWADDR_IN,
    input  wire logic              S_AXI_AWVALID_IN,
    output logic                   S_AXI_AWREADY_OUT,
    input  wire logic [31:0]       S_AXI_WDATA_IN,
    input  wire logic [3:0]        S_AXI_WSTRB_IN,
    input  wire logic              S_AXI_WVALID_IN,
    output logic                   S_AXI_WREADY_OUT,
    output logic [1:0]             S_AXI_BRESP_OUT,
    output logic                   S_AXI_BVALID_OUT,
    input  wire logic              S_AXI_BREADY_IN,
    input  wire logic [ADDR_W-1:0] S_AXI_ARADDR_IN,
    input  wire logic              S_AXI_ARVALID_IN,
    output logic                   S_AXI_ARREADY_OUT,
    output logic [31:0]            S_AXI_RDATA_OUT,
    output logic [1:0]             S_AXI_RRESP_OUT,
    output logic                   S_AXI_RVALID_OUT,
    input  wire logic              S_AXI_RREADY_IN,
    output logic                   INTERRUPT_OUT_N_FIRST_OUT,
    output logic                   INTERRUPT_OUT_N_SECOND_OUT,
    output logic                   IRQ_OUT
);

    localparam int unsigned N = isl_pkg::NUM_SRC;

    // ==========================================================
    // Declarations
    // ==========================================================
    logic [ADDR_W-1:0] aw_addr_ff;
    logic [ADDR_W-1:0] nxt_aw_addr;
    logic [31:0]       w_data_ff;
    logic [31:0]       nxt_w_data;
    logic [3:0]        w_strb_ff;
    logic [3:0]        nxt_w_strb;
    logic              aw_got_ff;
    logic              nxt_aw_got;
    logic              w_got_ff;
    logic              nxt_w_got;
    logic              bvalid_ff;
    logic              nxt_bvalid;
    logic [1:0]        bresp_ff;
    logic [1:0]        nxt_bresp;
    logic              rvalid_ff;
    logic              nxt_rvalid;
    logic [1:0]        rresp_ff;
    logic [1:0]        nxt_rresp;
    logic [31:0]       rdata_ff;
    logic [31:0]       nxt_rdata;

    logic [N-1:0]      latch_en_ff;
    logic [N-1:0]      nxt_latch_en;
    logic [N-1:0]      pin_sel_ff;
    logic [N-1:0]      nxt_pin_sel;
    logic [N-1:0]      evt_mask_ff;
    logic [N-1:0]      nxt_evt_mask;
    logic [N-1:0]      evt_status_ff;
    logic [N-1:0]      nxt_evt_status;
    logic              irq_ff;

    logic              aw_take;
    logic              w_take;
    logic              ar_take;
    logic              wr_fire;
    logic [7:0]        wr_idx;
    logic              wr_hi_ok;
    logic              wr_lane0;
    logic [7:0]        wr_byte;
    logic              wr_link;
    logic              wr_amp_a;
    logic              wr_amp_b;
    logic              wr_dll;
    logic              wr_en_reg;
    logic              wr_sel_reg;
    logic              wr_evt_st;
    logic              wr_evt_mk;
    logic              wr_mapped;

    logic [7:0]        rd_idx;
    logic              rd_hi_ok;
    logic              rd_mapped;
    logic [7:0]        rd_byte;

    logic [N-1:0]      src_live;
    logic [N-1:0]      src_clear;
    logic [N-1:0]      src_flag;
    logic [N-1:0]      src_request;
    logic [N-1:0]      src_event;

    logic [7:0]        link_word;
    logic [7:0]        amp_a_word;
    logic [7:0]        amp_b_word;
    logic [7:0]        dll_word;

    // ==========================================================
    // Source vector, slot order fixed by the package
    // ==========================================================
    assign src_live[isl_pkg::SRC_LANE]   = LANE_BUFFER_ERROR_IN;
    assign src_live[isl_pkg::SRC_JITTER] = STROBE_OUTSIDE_WINDOW_IN;
    assign src_live[isl_pkg::SRC_AMP0]   = AMP_ERROR_IN[0];
    assign src_live[isl_pkg::SRC_AMP1]   = AMP_ERROR_IN[1];
    assign src_live[isl_pkg::SRC_AMP2]   = AMP_ERROR_IN[2];
    assign src_live[isl_pkg::SRC_AMP3]   = AMP_ERROR_IN[3];
    assign src_live[isl_pkg::SRC_DLL_LO] = DELAY_LOOP_LOCKED_IN[0];
    assign src_live[isl_pkg::SRC_DLL_HI] = DELAY_LOOP_LOCKED_IN[1];

    // ==========================================================
    // Write channel handshakes
    // ==========================================================
    // Address and data held until both arrive, in either order
    assign S_AXI_AWREADY_OUT = !aw_got_ff && !bvalid_ff;
    assign S_AXI_WREADY_OUT  = !w_got_ff && !bvalid_ff;
    assign aw_take           = S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT;
    assign w_take            = S_AXI_WVALID_IN && S_AXI_WREADY_OUT;
    assign wr_fire           = aw_got_ff && w_got_ff && !bvalid_ff;

    assign nxt_aw_addr = aw_take ? S_AXI_AWADDR_IN : aw_addr_ff;
    assign nxt_w_data  = w_take ? S_AXI_WDATA_IN : w_data_ff;
    assign nxt_w_strb  = w_take ? S_AXI_WSTRB_IN : w_strb_ff;
    assign nxt_aw_got  = wr_fire ? 1'h0 : (aw_take ? 1'h1 : aw_got_ff);
    assign nxt_w_got   = wr_fire ? 1'h0 : (w_take ? 1'h1 : w_got_ff);
    assign nxt_bvalid  = wr_fire ? 1'h1 :
                         (S_AXI_BREADY_IN ? 1'h0 : bvalid_ff);
    assign nxt_bresp   = wr_fire ? (wr_mapped ? isl_pkg::RESP_OKAY :
                                    isl_pkg::RESP_DECERR) : bresp_ff;

    // ==========================================================
    // Write decode
    // ==========================================================
    assign wr_idx     = aw_addr_ff[9:2];
    assign wr_hi_ok   = (aw_addr_ff[ADDR_W-1:10] == '0);
    assign wr_lane0   = wr_fire && wr_hi_ok && w_strb_ff[0];
    assign wr_byte    = w_data_ff[7:0];
    assign wr_link    = wr_lane0 && (wr_idx == isl_pkg::IDX_LINK_EVENT);
    assign wr_amp_a   = wr_lane0 && (wr_idx == isl_pkg::IDX_AMP_A);
    assign wr_amp_b   = wr_lane0 && (wr_idx == isl_pkg::IDX_AMP_B);
    assign wr_dll     = wr_lane0 && (wr_idx == isl_pkg::IDX_DLL_LOCK);
    assign wr_en_reg  = wr_lane0 && (wr_idx == isl_pkg::IDX_LATCH_EN);
    assign wr_sel_reg = wr_lane0 && (wr_idx == isl_pkg::IDX_PIN_SEL);
    assign wr_evt_st  = wr_lane0 && (wr_idx == isl_pkg::IDX_EVT_STATUS);
    assign wr_evt_mk  = wr_lane0 && (wr_idx == isl_pkg::IDX_EVT_MASK);
    assign wr_mapped  = wr_hi_ok &&
                        ((wr_idx == isl_pkg::IDX_LINK_EVENT) ||
                         (wr_idx == isl_pkg::IDX_AMP_A) ||
                         (wr_idx == isl_pkg::IDX_AMP_B) ||
                         (wr_idx == isl_pkg::IDX_DLL_LOCK) ||
                         (wr_idx == isl_pkg::IDX_LATCH_EN) ||
                         (wr_idx == isl_pkg::IDX_PIN_SEL) ||
                         (wr_idx == isl_pkg::IDX_EVT_STATUS) ||
                         (wr_idx == isl_pkg::IDX_EVT_MASK));

    // ==========================================================
    // Clear requests toward the flag cells
    // ==========================================================
    // Lane and jitter flags clear on any write with byte lane 0 strobed to the link event register, whatever the data
    assign src_clear[isl_pkg::SRC_LANE]   = wr_link;
    assign src_clear[isl_pkg::SRC_JITTER] = wr_link;
    assign src_clear[isl_pkg::SRC_AMP0]   =
        wr_amp_a && wr_byte[isl_pkg::BIT_AMP_LO];
    assign src_clear[isl_pkg::SRC_AMP1]   =
        wr_amp_a && wr_byte[isl_pkg::BIT_AMP_HI];
    assign src_clear[isl_pkg::SRC_AMP2]   =
        wr_amp_b && wr_byte[isl_pkg::BIT_AMP_LO];
    assign src_clear[isl_pkg::SRC_AMP3]   =
        wr_amp_b && wr_byte[isl_pkg::BIT_AMP_HI];
    assign src_clear[isl_pkg::SRC_DLL_LO] =
        wr_dll && wr_byte[isl_pkg::BIT_DLL_LO];
    assign src_clear[isl_pkg::SRC_DLL_HI] =
        wr_dll && wr_byte[isl_pkg::BIT_DLL_HI];

    // ==========================================================
    // Control registers
    // ==========================================================
    assign nxt_latch_en = wr_en_reg ? wr_byte : latch_en_ff;
    assign nxt_pin_sel  = wr_sel_reg ? wr_byte : pin_sel_ff;
    assign nxt_evt_mask = wr_evt_mk ? wr_byte : evt_mask_ff;
    // New events win over a write-one clear in the same cycle
    assign nxt_evt_status = (evt_status_ff & ~(wr_evt_st ? wr_byte : '0))
                            | src_event;

    // ==========================================================
    // Flag cells, one per source
    // ==========================================================
    genvar gi;
    generate
        for (gi = 0; gi < N; gi++) begin : g_src
            isl_flag_cell u_cell (
                .clk_in      (REF_CLK_IN),
                .rst_in      (SYS_RST_IN),
                .latch_en_in (latch_en_ff[gi]),
                .live_in     (src_live[gi]),
                .clear_in    (src_clear[gi]),
                .flag_out    (src_flag[gi]),
                .request_out (src_request[gi]),
                .event_out   (src_event[gi])
            );
        end
    endgenerate

    // ==========================================================
    // Status words, reserved bits read zero
    // ==========================================================
    always_comb begin
        link_word  = isl_pkg::RST_REG;
        amp_a_word = isl_pkg::RST_REG;
        amp_b_word = isl_pkg::RST_REG;
        dll_word   = isl_pkg::RST_REG;
        link_word[isl_pkg::BIT_LANE]    = src_flag[isl_pkg::SRC_LANE];
        link_word[isl_pkg::BIT_JITTER]  = src_flag[isl_pkg::SRC_JITTER];
        amp_a_word[isl_pkg::BIT_AMP_HI] = src_flag[isl_pkg::SRC_AMP1];
        amp_a_word[isl_pkg::BIT_AMP_LO] = src_flag[isl_pkg::SRC_AMP0];
        amp_b_word[isl_pkg::BIT_AMP_HI] = src_flag[isl_pkg::SRC_AMP3];
        amp_b_word[isl_pkg::BIT_AMP_LO] = src_flag[isl_pkg::SRC_AMP2];
        dll_word[isl_pkg::BIT_DLL_HI]   = src_flag[isl_pkg::SRC_DLL_HI];
        dll_word[isl_pkg::BIT_DLL_LO]   = src_flag[isl_pkg::SRC_DLL_LO];
    end

    // ==========================================================
    // Read channel
    // ==========================================================
    // One read outstanding; address is taken only when idle
    assign S_AXI_ARREADY_OUT = !rvalid_ff;
    assign ar_take   = S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT;
    assign rd_idx    = S_AXI_ARADDR_IN[9:2];
    assign rd_hi_ok  = (S_AXI_ARADDR_IN[ADDR_W-1:10] == '0);
    assign rd_byte   = (rd_idx == isl_pkg::IDX_LINK_EVENT) ? link_word :
                       (rd_idx == isl_pkg::IDX_AMP_A)      ? amp_a_word :
                       (rd_idx == isl_pkg::IDX_AMP_B)      ? amp_b_word :
                       (rd_idx == isl_pkg::IDX_DLL_LOCK)   ? dll_word :
                       (rd_idx == isl_pkg::IDX_LATCH_EN)   ? latch_en_ff :
                       (rd_idx == isl_pkg::IDX_PIN_SEL)    ? pin_sel_ff :
                       (rd_idx == isl_pkg::IDX_EVT_STATUS) ? evt_status_ff :
                       (rd_idx == isl_pkg::IDX_EVT_MASK)   ? evt_mask_ff :
                                                             isl_pkg::RST_REG;
    assign rd_mapped = rd_hi_ok &&
                       ((rd_idx == isl_pkg::IDX_LINK_EVENT) ||
                        (rd_idx == isl_pkg::IDX_AMP_A) ||
                        (rd_idx == isl_pkg::IDX_AMP_B) ||
                        (rd_idx == isl_pkg::IDX_DLL_LOCK) ||
                        (rd_idx == isl_pkg::IDX_LATCH_EN) ||
                        (rd_idx == isl_pkg::IDX_PIN_SEL) ||
                        (rd_idx == isl_pkg::IDX_EVT_STATUS) ||
                        (rd_idx == isl_pkg::IDX_EVT_MASK));

    assign nxt_rvalid = ar_take ? 1'h1 :
                        (S_AXI_RREADY_IN ? 1'h0 : rvalid_ff);
    assign nxt_rdata  = !ar_take ? rdata_ff :
                        rd_mapped ? {24'h00_0000, rd_byte} : isl_pkg::RST_WORD;
    assign nxt_rresp  = !ar_take ? rresp_ff :
                        rd_mapped ? isl_pkg::RESP_OKAY : isl_pkg::RESP_DECERR;

    // ==========================================================
    // Bus state registers
    // ==========================================================
    always_ff @(posedge REF_CLK_IN) begin
        if (SYS_RST_IN) begin
            aw_got_ff <= 1'h0;
            w_got_ff  <= 1'h0;
            bvalid_ff <= 1'h0;
            bresp_ff  <= isl_pkg::RESP_OKAY;
            rvalid_ff <= 1'h0;
            rresp_ff  <= isl_pkg::RESP_OKAY;
            rdata_ff  <= isl_pkg::RST_WORD;
        end else begin
            aw_got_ff <= nxt_aw_got;
            w_got_ff  <= nxt_w_got;
            bvalid_ff <= nxt_bvalid;
            bresp_ff  <= nxt_bresp;
            rvalid_ff <= nxt_rvalid;
            rresp_ff  <= nxt_rresp;
            rdata_ff  <= nxt_rdata;
        end
    end

    // Payload holders need no reset, they are qualified by the flags
    always_ff @(posedge REF_CLK_IN) begin
        aw_addr_ff <= nxt_aw_addr;
        w_data_ff  <= nxt_w_data;
        w_strb_ff  <= nxt_w_strb;
    end

    // ==========================================================
    // Control and event registers
    // ==========================================================
    always_ff @(posedge REF_CLK_IN) begin
        if (SYS_RST_IN) begin
            latch_en_ff   <= isl_pkg::RST_REG;
            pin_sel_ff    <= isl_pkg::RST_REG;
            evt_mask_ff   <= isl_pkg::RST_REG;
            evt_status_ff <= isl_pkg::RST_REG;
            irq_ff        <= 1'h0;
        end else begin
            latch_en_ff   <= nxt_latch_en;
            pin_sel_ff    <= nxt_pin_sel;
            evt_mask_ff   <= nxt_evt_mask;
            evt_status_ff <= nxt_evt_status;
            irq_ff        <= |(evt_status_ff & evt_mask_ff);
        end
    end

    // ==========================================================
    // Interrupt pins
    // ==========================================================
    isl_irq_pin #(
        .NUM_SRC  (N),
        .PIN_CODE (1'h0)
    ) u_pin_first (
        .clk_in     (REF_CLK_IN),
        .rst_in     (SYS_RST_IN),
        .request_in (src_request),
        .pin_sel_in (pin_sel_ff),
        .pin_n_out  (INTERRUPT_OUT_N_FIRST_OUT)
    );

    isl_irq_pin #(
        .NUM_SRC  (N),
        .PIN_CODE (1'h1)
    ) u_pin_second (
        .clk_in     (REF_CLK_IN),
        .rst_in     (SYS_RST_IN),
        .request_in (src_request),
        .pin_sel_in (pin_sel_ff),
        .pin_n_out  (INTERRUPT_OUT_N_SECOND_OUT)
    );

    // ==========================================================
    // Bus outputs
    // ==========================================================
    assign S_AXI_BVALID_OUT = bvalid_ff;
    assign S_AXI_BRESP_OUT  = bresp_ff;
    assign S_AXI_RVALID_OUT = rvalid_ff;
    assign S_AXI_RRESP_OUT  = rresp_ff;
    assign S_AXI_RDATA_OUT  = rdata_ff;
    assign IRQ_OUT          = irq_ff;

endmodule

// >>> tb/isl_status_bank_assertions.sv
// Port-level checks of the interrupt status latch bank
`timescale 1ns/100ps
module isl_status_bank_chk (
    input wire logic        REF_CLK_IN,
    input wire logic        SYS_RST_IN,
    input wire logic        LANE_BUFFER_ERROR_IN,
    input wire logic        STROBE_OUTSIDE_WINDOW_IN,
    input wire logic [3:0]  AMP_ERROR_IN,
    input wire logic [1:0]  DELAY_LOOP_LOCKED_IN,
    input wire logic        S_AXI_ARVALID_IN,
    input wire logic        S_AXI_ARREADY_OUT,
    input wire logic        S_AXI_RVALID_OUT,
    input wire logic        S_AXI_RREADY_IN,
    input wire logic [31:0] S_AXI_RDATA_OUT,
    input wire logic [1:0]  S_AXI_RRESP_OUT,
    input wire logic        S_AXI_BVALID_OUT,
    input wire logic        S_AXI_BREADY_IN,
    input wire logic        INTERRUPT_OUT_N_FIRST_OUT,
    input wire logic        INTERRUPT_OUT_N_SECOND_OUT,
    input wire logic        IRQ_OUT
);
    // ==========================================================
    // Helpers
    // ==========================================================
    // A pin may also move after a routing or enable write, hence BVALID
    wire logic any_src = LANE_BUFFER_ERROR_IN | STROBE_OUTSIDE_WINDOW_IN
                       | (|AMP_ERROR_IN) | (|DELAY_LOOP_LOCKED_IN);
    default clocking @(posedge REF_CLK_IN); endclocking
    default disable iff (SYS_RST_IN);
    sequence s_rd_taken;
        S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT;
    endsequence
    // ==========================================================
    // Assertions
    // ==========================================================
    a_rst_pins_idle: assert property (disable iff (1'h0) SYS_RST_IN |=>
        INTERRUPT_OUT_N_FIRST_OUT && INTERRUPT_OUT_N_SECOND_OUT && !IRQ_OUT)
        else $error("pins not idle after reset");
    a_rst_bus_idle: assert property (disable iff (1'h0) SYS_RST_IN |=>
        !S_AXI_BVALID_OUT && !S_AXI_RVALID_OUT) else $error("bus busy after reset");
    a_first_fall_cause: assert property ($fell(INTERRUPT_OUT_N_FIRST_OUT) |->
        $past(any_src, 2) || $past(S_AXI_BVALID_OUT)) else $error("first pin fell");
    a_second_fall_cause: assert property ($fell(INTERRUPT_OUT_N_SECOND_OUT) |->
        $past(any_src, 2) || $past(S_AXI_BVALID_OUT)) else $error("second pin fell");
    a_first_rise_clear: assert property ($rose(INTERRUPT_OUT_N_FIRST_OUT) |->
        $past(S_AXI_BVALID_OUT)) else $error("first pin released without write");
    a_read_answer: assert property (s_rd_taken |=> S_AXI_RVALID_OUT)
        else $error("read not answered");
    a_read_holds: assert property (S_AXI_RVALID_OUT && !S_AXI_RREADY_IN |=>
        S_AXI_RVALID_OUT && $stable(S_AXI_RDATA_OUT)) else $error("read data dropped");
    a_write_holds: assert property (S_AXI_BVALID_OUT && !S_AXI_BREADY_IN |=>
        S_AXI_BVALID_OUT) else $error("write answer dropped");
    a_decerr_zero: assert property (S_AXI_RVALID_OUT && S_AXI_RRESP_OUT == 2'h3 |->
        S_AXI_RDATA_OUT == 32'h0) else $error("unmapped read data not zero");
endmodule
bind isl_status_bank isl_status_bank_chk u_isl_status_bank_chk (.*);

// >>> tb/isl_host_model.sv
// Host side: samples the two active-low interrupt pins
`timescale 1ns/100ps
module isl_host_model (
    input  wire logic  clk_in,
    input  wire logic  pin_first_n_in,
    input  wire logic  pin_second_n_in,
    output logic [1:0] pending_out
);
    // One sample per clock, no glitch filter: a host would debounce
    always_ff @(posedge clk_in) begin
        pending_out <= {~pin_second_n_in, ~pin_first_n_in};
    end
endmodule

// >>> tb/tb_isl_status_bank.sv
// Directed testbench of the interrupt status latch bank
`timescale 1ns/100ps
module tb_isl_status_bank;
    logic clk = 1'h0, rst = 1'h1, awv = 1'h0, wv = 1'h0, br = 1'h0, arv = 1'h0, rr = 1'h0;
    logic [7:0] src = 8'h00;
    logic [11:0] awa = 12'h000, ara = 12'h000;
    logic [31:0] wd = 32'h0;
    wire logic awr, wr_r, bv, arr, rv, p1, p2, irq;
    wire logic [1:0] bresp, rresp, pend;
    wire logic [31:0] rdata;
    int err_count = 0, compares = 0;
    always #5 clk = ~clk;
    isl_status_bank u_isl_status_bank (.REF_CLK_IN(clk), .SYS_RST_IN(rst),
        .LANE_BUFFER_ERROR_IN(src[0]), .STROBE_OUTSIDE_WINDOW_IN(src[1]),
        .AMP_ERROR_IN(src[5:2]), .DELAY_LOOP_LOCKED_IN(src[7:6]), .S_AXI_AWADDR_IN(awa),
        .S_AXI_AWVALID_IN(awv), .S_AXI_AWREADY_OUT(awr), .S_AXI_WDATA_IN(wd),
        .S_AXI_WSTRB_IN(4'hF), .S_AXI_WVALID_IN(wv), .S_AXI_WREADY_OUT(wr_r),
        .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bv), .S_AXI_BREADY_IN(br),
        .S_AXI_ARADDR_IN(ara), .S_AXI_ARVALID_IN(arv), .S_AXI_ARREADY_OUT(arr),
        .S_AXI_RDATA_OUT(rdata), .S_AXI_RRESP_OUT(rresp), .S_AXI_RVALID_OUT(rv),
        .S_AXI_RREADY_IN(rr), .INTERRUPT_OUT_N_FIRST_OUT(p1),
        .INTERRUPT_OUT_N_SECOND_OUT(p2), .IRQ_OUT(irq));
    isl_host_model u_isl_host_model (.clk_in(clk), .pin_first_n_in(p1),
        .pin_second_n_in(p2), .pending_out(pend));
    // ==========================================================
    // Shared tasks
    // ==========================================================
    task chk(input string n, input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", n, exp, got);
        end
    endtask
    // Ready is looked at mid-cycle, so the edge that takes an item is known
    task wr(input logic [11:0] a, input logic [31:0] d);
        logic ta, tw;
        @(posedge clk);
        awa <= a;
        wd <= d;
        awv <= 1'h1;
        wv <= 1'h1;
        do begin
            @(negedge clk);
            ta = awr & awv;
            tw = wr_r & wv;
            @(posedge clk);
            if (ta) awv <= 1'h0;
            if (tw) wv <= 1'h0;
        end while (awv && !ta || wv && !tw);
        do @(negedge clk); while (!bv);
        @(posedge clk) br <= 1'h1;
        @(negedge clk) chk("bresp", bresp, 2'h0);
        @(posedge clk) br <= 1'h0;
    endtask
    task rd(input logic [11:0] a, input logic [7:0] exp, input logic [1:0] er = 2'h0);
        logic t;
        @(posedge clk);
        ara <= a;
        arv <= 1'h1;
        do begin
            @(negedge clk);
            t = arr;
            @(posedge clk);
        end while (!t);
        arv <= 1'h0;
        do @(negedge clk); while (!rv);
        @(posedge clk) rr <= 1'h1;
        @(negedge clk) chk("rdata", rdata, {24'h0, exp});
        chk("rresp", rresp, er);
        @(posedge clk) rr <= 1'h0;
    endtask
    task pulse(input logic [7:0] v);
        @(posedge clk) src <= v;
        @(posedge clk) src <= 8'h00;
        repeat (4) @(negedge clk);
    endtask
    task tally_and_finish;
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // ==========================================================
    // Scenarios: byte address is four times the register index
    // ==========================================================
    task t_reset;
        for (int i = 0; i < 4; i++) rd(12'h098 + 12'(4 * i), 8'h00);
        rd(12'hC9C, 8'h00, 2'h3);
        chk("pins", {p2, p1}, 2'h3);
        $display("test reset done");
    endtask
    task t_live;
        @(posedge clk) src <= 8'hFF;
        rd(12'h098, 8'h24);
        rd(12'h09C, 8'h88);
        rd(12'h0A0, 8'h88);
        rd(12'h0A4, 8'h50);
        chk("pins", {p2, p1}, 2'h3);
        @(posedge clk) src <= 8'h00;
        rd(12'h098, 8'h00);
        $display("test live done");
    endtask
    task t_latch;
        wr(12'h080, 32'hFF);
        pulse(8'hFF);
        rd(12'h098, 8'h24);
        rd(12'h0A4, 8'h50);
        chk("pins", {pend, p2, p1}, 4'h6);
        wr(12'h098, 32'h0);
        rd(12'h098, 8'h00);
        wr(12'h09C, 32'h80);
        rd(12'h09C, 8'h08);
        wr(12'h09C, 32'h08);
        wr(12'h0A0, 32'h88);
        wr(12'h0A4, 32'h50);
        rd(12'h0A0, 8'h00);
        chk("pins", {p2, p1}, 2'h3);
        $display("test latch done");
    endtask
    task t_route;
        wr(12'h0B0, 32'h01);
        pulse(8'h01);
        chk("pins", {p2, p1}, 2'h1);
        wr(12'h098, 32'hFFFF_FFFF);
        pulse(8'h02);
        chk("pins", {p2, p1}, 2'h2);
        wr(12'h098, 32'h0);
        rd(12'h098, 8'h00);
        $display("test route done");
    endtask
    task t_irq;
        wr(12'h0C0, 32'hFF);
        wr(12'h0C4, 32'h01);
        pulse(8'h02);
        rd(12'h0C0, 8'h02);
        chk("irq", irq, 1'h0);
        pulse(8'h01);
        chk("irq", irq, 1'h1);
        wr(12'h0C0, 32'h03);
        repeat (2) @(negedge clk);
        chk("irq", irq, 1'h0);
        $display("test irq done");
    endtask
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'h0;
        t_reset;
        t_live;
        t_latch;
        t_route;
        t_irq;
        tally_and_finish;
    end
    initial begin
        #200us;
        err_count++;
        tally_and_finish;
    end
endmodule
